// ===== core/sfsrc_top.sv
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// - regulator unregulated sets masked status bit 2
// - writing one clears regulator status; zero leaves it
// - brown-out detection sets masked status bit 1
// - brown-out interrupt only when mask set and reset-select clear
// - writing one clears brown-out status
// - reset-cause register shows source(s) of every reset since the last power-on, external reset or write
// - external reset sets its bit and clears all others
// - other resets except power-on keep old cause bits and add the new one; power-on leaves only bit 1
// - reset-cause register decoded at offset 0x05C
// - regulator-loss reset sets cause bit 5
module sfsrc_top
(
  // clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic por_rst,
  // fault events, levels or pulses
  input wire logic regulator_unregulated,
  input wire logic brownout_detect,
  input wire logic main_osc_fault,
  input wire logic internal_osc_fault,
  // reset causes, one-cycle pulses
  input wire logic ext_reset_evt,
  input wire logic brownout_reset_evt,
  input wire logic watchdog_reset_evt,
  input wire logic software_reset_evt,
  input wire logic regulator_loss_reset_evt,
  // axi4-lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // brown-out interrupt level
  output logic brownout_irq
);
  logic [4:0] mis_r, mis_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [5:0] cause_r;
  logic [5:0] cause_evt;
  logic wr_go, rd_go, cause_wr;
  logic [4:0] fault_set, w1c;

  function automatic logic mapped(input logic [11:0] a);
    return a == sfsrc_pkg::SFSRC_STAT_OFF || a == sfsrc_pkg::SFSRC_CAUSE_OFF || a == sfsrc_pkg::SFSRC_CTRL_OFF;
  endfunction : mapped

  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign wr_go = aw_have_r && w_have_r;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign cause_wr = wr_go && awaddr_r == sfsrc_pkg::SFSRC_CAUSE_OFF && wstrb_r[0];
  assign brownout_irq = mis_r[sfsrc_pkg::SFSRC_BROWN_MIS_BIT]
                        && ctrl_r[sfsrc_pkg::SFSRC_BROWN_MASK_BIT] && !ctrl_r[sfsrc_pkg::SFSRC_BROWN_SEL_BIT];
  assign cause_evt = {regulator_loss_reset_evt, software_reset_evt, watchdog_reset_evt,
                      brownout_reset_evt, 1'b0, ext_reset_evt};

  always_comb
  begin
    fault_set = 5'h00;
    fault_set[sfsrc_pkg::SFSRC_REG_MIS_BIT] = regulator_unregulated;
    fault_set[sfsrc_pkg::SFSRC_BROWN_MIS_BIT] = brownout_detect;
    fault_set[sfsrc_pkg::SFSRC_MOF_MIS_BIT] = main_osc_fault;
    fault_set[sfsrc_pkg::SFSRC_IOF_MIS_BIT] = internal_osc_fault;
    w1c = 5'h00;
    if (wr_go && awaddr_r == sfsrc_pkg::SFSRC_STAT_OFF && wstrb_r[0])
    begin
      w1c = wdata_r[4:0] & 5'h1E;
    end
  end

  always_comb
  begin
    mis_nxt = (mis_r & ~w1c) | fault_set;
    ctrl_nxt = ctrl_r;
    if (wr_go && awaddr_r == sfsrc_pkg::SFSRC_CTRL_OFF && wstrb_r[0])
    begin
      ctrl_nxt = wdata_r[1:0];
    end
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awaddr_nxt = {s_axi_awaddr[11:2], 2'h0};
      aw_have_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
      w_have_nxt = 1'b1;
    end
    if (wr_go)
    begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(awaddr_r) ? sfsrc_pkg::SFSRC_RESP_OKAY : sfsrc_pkg::SFSRC_RESP_SLVERR;
    end
    else if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (rd_go)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = mapped({s_axi_araddr[11:2], 2'h0}) ? sfsrc_pkg::SFSRC_RESP_OKAY : sfsrc_pkg::SFSRC_RESP_SLVERR;
      case ({s_axi_araddr[11:2], 2'h0})
        sfsrc_pkg::SFSRC_STAT_OFF: rdata_nxt = {27'h0, mis_r};
        sfsrc_pkg::SFSRC_CAUSE_OFF: rdata_nxt = {26'h0, cause_r};
        sfsrc_pkg::SFSRC_CTRL_OFF: rdata_nxt = {30'h0, ctrl_r};
        default: rdata_nxt = 32'h0;
      endcase
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mis_r <= sfsrc_pkg::SFSRC_MIS_RST;
      ctrl_r <= sfsrc_pkg::SFSRC_CTRL_RST;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h0;
    end
    else
    begin
      mis_r <= mis_nxt;
      ctrl_r <= ctrl_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  sfsrc_cause u_cause
  (
    .clk(clk),
    .por_rst(por_rst),
    .cause_evt(cause_evt),
    .wr_en(cause_wr),
    .wr_data(wdata_r[5:0]),
    .cause_r(cause_r)
  );

  property p_reg_set;
    @(posedge clk) disable iff (rst) regulator_unregulated |=> mis_r[2];
  endproperty
  a_reg_set: assert property (p_reg_set) else $error("regulator status not set");

  property p_reg_clr;
    @(posedge clk) disable iff (rst) (w1c[2] && !regulator_unregulated) |=> !mis_r[2];
  endproperty
  a_reg_clr: assert property (p_reg_clr) else $error("regulator status not cleared");

  property p_brown_set;
    @(posedge clk) disable iff (rst) brownout_detect |=> mis_r[1];
  endproperty
  a_brown_set: assert property (p_brown_set) else $error("brown-out status not set");

  // tied to the detect input, not to the status flop, so a broken gate shows
  property p_irq;
    @(posedge clk) disable iff (rst)
      ($past(brownout_detect) && !$past(rst) && ctrl_r[0] && !ctrl_r[1]) |-> brownout_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("brown-out interrupt missing");

  property p_brown_clr;
    @(posedge clk) disable iff (rst) (w1c[1] && !brownout_detect) |=> !mis_r[1];
  endproperty
  a_brown_clr: assert property (p_brown_clr) else $error("brown-out status not cleared");

  property p_osc;
    @(posedge clk) disable iff (rst) (main_osc_fault || internal_osc_fault)
      |=> (mis_r[3] || !$past(main_osc_fault)) && (mis_r[4] || !$past(internal_osc_fault));
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator status not set");

  property p_hold;
    @(posedge clk) disable iff (rst) (mis_r[2] && !w1c[2]) |=> mis_r[2];
  endproperty
  a_hold: assert property (p_hold) else $error("regulator status dropped without write");

  property p_regloss_cause;
    @(posedge clk) disable iff (por_rst) (regulator_loss_reset_evt && !ext_reset_evt) |=> cause_r[5];
  endproperty
  a_regloss_cause: assert property (p_regloss_cause) else $error("regulator-loss cause not recorded");

  property p_cause_read;
    @(posedge clk) disable iff (rst) (rd_go && s_axi_araddr == sfsrc_pkg::SFSRC_CAUSE_OFF)
      |=> s_axi_rvalid && s_axi_rdata[31:6] == 26'h0;
  endproperty
  a_cause_read: assert property (p_cause_read) else $error("cause read malformed");
endmodule : sfsrc_top

// ===== core/sfsrc_pkg.sv
package sfsrc_pkg;
  // byte addresses on the register bus
  localparam logic [11:0] SFSRC_STAT_OFF = 12'h058;
  localparam logic [11:0] SFSRC_CAUSE_OFF = 12'h05C;
  localparam logic [11:0] SFSRC_CTRL_OFF = 12'h064;
  // masked status bit positions
  localparam int SFSRC_BROWN_MIS_BIT = 1;
  localparam int SFSRC_REG_MIS_BIT = 2;
  localparam int SFSRC_MOF_MIS_BIT = 3;
  localparam int SFSRC_IOF_MIS_BIT = 4;
  // control register bit positions
  localparam int SFSRC_BROWN_MASK_BIT = 0;
  localparam int SFSRC_BROWN_SEL_BIT = 1;
  // reset cause bit positions
  localparam int SFSRC_CAUSE_W = 6;
  localparam int SFSRC_EXT_BIT = 0;
  localparam int SFSRC_POR_BIT = 1;
  localparam int SFSRC_BROWN_BIT = 2;
  localparam int SFSRC_DOG_BIT = 3;
  localparam int SFSRC_SOFT_BIT = 4;
  localparam int SFSRC_REG_BIT = 5;
  // reset values and response codes
  localparam logic [4:0] SFSRC_MIS_RST = 5'h00;
  localparam logic [1:0] SFSRC_CTRL_RST = 2'h0;
  localparam logic [1:0] SFSRC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SFSRC_RESP_SLVERR = 2'h2;
endpackage : sfsrc_pkg

// ===== core/sfsrc_cause.sv
`timescale 1ns/100ps
// reset-cause record; lives in the por_rst domain, so power-on and external reset are the only causes it records that clear it
module sfsrc_cause
(
  // clock and record reset
  input wire logic clk,
  input wire logic por_rst,
  // reset events, one-cycle pulses
  input wire logic [5:0] cause_evt,
  // software write
  input wire logic wr_en,
  input wire logic [5:0] wr_data,
  // record
  output logic [5:0] cause_r
);
  logic [5:0] cause_nxt;

  always_comb
  begin
    cause_nxt = cause_r;
    if (wr_en)
    begin
      cause_nxt = wr_data;
    end
    if (cause_evt[sfsrc_pkg::SFSRC_EXT_BIT])
    begin
      cause_nxt = 6'h01;
    end
    else if (|cause_evt)
    begin
      cause_nxt = cause_nxt | cause_evt;
    end
  end

  // power-on clears the record then notes itself
  always_ff @(posedge clk)
  begin
    if (por_rst)
    begin
      cause_r <= 6'h02;
    end
    else
    begin
      cause_r <= cause_nxt;
    end
  end

  property p_ext_only;
    @(posedge clk) disable iff (por_rst) cause_evt[0] |=> cause_r == 6'h01;
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("external reset left other causes");

  property p_sticky;
    @(posedge clk) disable iff (por_rst) (!cause_evt[0] && |cause_evt && !wr_en)
      |=> ((cause_r & $past(cause_r)) == $past(cause_r)) && ((cause_r & $past(cause_evt)) == $past(cause_evt));
  endproperty
  a_sticky: assert property (p_sticky) else $error("cause bits lost or not added");
endmodule : sfsrc_cause

// ===== test/sysctl_fault_status_reset_cause_tb_top.sv
`timescale 1ns/100ps
module sysctl_fault_status_reset_cause_tb_top;
  localparam logic [11:0] sta = sfsrc_pkg::SFSRC_STAT_OFF;
  localparam logic [11:0] cau = sfsrc_pkg::SFSRC_CAUSE_OFF;
  localparam logic [11:0] ctl = sfsrc_pkg::SFSRC_CTRL_OFF;
  localparam logic [1:0] ok = sfsrc_pkg::SFSRC_RESP_OKAY;
  localparam logic [1:0] err = sfsrc_pkg::SFSRC_RESP_SLVERR;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic por_rst = 1'h1;
  logic [4:0] flt = 5'h00;
  logic [5:0] rev = 6'h00;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, w;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, cr;
  logic [31:0] rdata;
  logic [34:0] e;
  logic [34:0] rq[$];
  logic [1:0] bq[$];
  logic [5:0] c;
  logic [4:0] s;
  int fails = 0, total_checks = 0, cyc = 0;

  always #20 clk = ~clk;

  sfsrc_top dut
  (
    .clk(clk), .rst(rst), .por_rst(por_rst),
    .regulator_unregulated(flt[2]), .brownout_detect(flt[1]),
    .main_osc_fault(flt[3]), .internal_osc_fault(flt[4]),
    .ext_reset_evt(rev[0]), .brownout_reset_evt(rev[2]), .watchdog_reset_evt(rev[3]),
    .software_reset_evt(rev[4]), .regulator_loss_reset_evt(rev[5]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .brownout_irq(irq)
  );

  task conclude;
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task tally(input bit good, input string m);
    total_checks++;
    if (!good)
    begin
      fails++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask : tally

  task chk_data(input logic [31:0] x, input logic [31:0] g);
    tally(g === x, "read data");
  endtask : chk_data

  task chk_resp(input logic [1:0] x, input logic [1:0] g);
    tally(g === x, "response code");
  endtask : chk_resp

  task chk_irq(input logic x, input logic g);
    tally(g === x, "brown-out interrupt level");
  endtask : chk_irq

  // each channel released at the edge that takes it
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awready && awvalid)
        awvalid <= 1'h0;
      if (wready && wvalid)
        wvalid <= 1'h0;
    end
    while (!(bvalid && bready));
    bready <= 1'h0;
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({s[1] & cr[0] & ~cr[1], r, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arready && arvalid)
        arvalid <= 1'h0;
    end
    while (!(rvalid && rready));
    rready <= 1'h0;
  endtask : rd

  task pulse(input logic [4:0] f, input logic [5:0] r);
    @(posedge clk);
    flt <= f;
    rev <= r;
    @(posedge clk);
    flt <= 5'h00;
    rev <= 6'h00;
  endtask : pulse

  always @(posedge clk)
  begin
    if (rvalid && rready)
    begin
      e = rq.pop_front();
      chk_data(e[31:0], rdata);
      chk_resp(e[33:32], rresp);
      chk_irq(e[34], irq);
    end
    if (bvalid && bready)
      chk_resp(bq.pop_front(), bresp);
    cyc++;
    // bound well above the few hundred cycles the run needs
    if (cyc == 4000)
    begin
      fails++;
      conclude();
    end
  end

  initial
  begin
    void'($urandom(32'hA35DB589));
    s = 5'h00;
    c = 6'h02;
    cr = 2'h0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    por_rst <= 1'h0;
    rd(cau, {26'h0, c}, ok);
    rd(sta, {27'h0, s}, ok);
    rd(12'h100, 32'h0, err);
    wr(12'h100, 32'h1, err);
    for (int i = 2; i < 5; i++)
    begin
      pulse(5'h01 << i, 6'h00);
      s[i] = 1'h1;
      rd(sta, {27'h0, s}, ok);
      wr(sta, 32'h0, ok);
      rd(sta, {27'h0, s}, ok);
      wr(sta, 32'h1 << i, ok);
      s[i] = 1'h0;
      rd(sta, {27'h0, s}, ok);
    end
    pulse(5'h02, 6'h00);
    s[1] = 1'h1;
    for (int k = 0; k < 4; k++)
    begin
      cr = k[1:0];
      wr(ctl, {30'h0, cr}, ok);
      rd(sta, {27'h0, s}, ok);
    end
    cr = 2'h1;
    wr(ctl, {30'h0, cr}, ok);
    wr(sta, 32'h2, ok);
    s[1] = 1'h0;
    rd(sta, {27'h0, s}, ok);
    for (int j = 2; j < 6; j++)
    begin
      pulse(5'h00, 6'h01 << j);
      c[j] = 1'h1;
      rd(cau, {26'h0, c}, ok);
    end
    pulse(5'h00, 6'h01);
    c = 6'h01;
    rd(cau, {26'h0, c}, ok);
    pulse(5'h00, 6'h08);
    c = 6'h09;
    rd(cau, {26'h0, c}, ok);
    repeat (4)
    begin
      w = $urandom;
      wr(cau, w, ok);
      c = w[5:0];
      rd(cau, {26'h0, c}, ok);
    end
    w = $urandom;
    pulse({w[4:1], 1'h0}, 6'h00);
    s = {w[4:1], 1'h0};
    rd(sta, {27'h0, s}, ok);
    // status cleared by rst, cause record kept
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    s = 5'h00;
    cr = 2'h0;
    rd(cau, {26'h0, c}, ok);
    rd(sta, {27'h0, s}, ok);
    conclude();
  end
endmodule : sysctl_fault_status_reset_cause_tb_top
